/* File: rtl/eei_dev.sv */
`default_nettype none
module eei_dev
    import eei_pkg::*;
#(
    parameter int EW_CNT = EW_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    eei_if.dev bus,
    input wire logic wp,
    output logic busy,
    output logic [ADDR_W-1:0] cur_addr
);
    // =====================================================
    // Synchronisers and edge detection
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] wp_sync_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_s, sda_s, wp_s, scl_rise, scl_fall, start_det, stop_det;

    // Two-flop synchronisers
    always_ff @(posedge clk) begin
        scl_sync_reg <= {scl_sync_reg[0], bus.scl};
        sda_sync_reg <= {sda_sync_reg[0], bus.sda};
        wp_sync_reg <= {wp_sync_reg[0], wp};
    end

    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign wp_s = wp_sync_reg[1];

    // Delayed copies for edges
    always_ff @(posedge clk) begin
        if (srst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // Edges sampled at our clock cover all three rates
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // =====================================================
    // Protocol state
    typedef enum logic [2:0] {
        ST_IDLE, ST_SEL, ST_WADDR, ST_WDATA, ST_RDATA, ST_RACK
    } eei_state_e;

    eei_state_e state_reg;
    logic [3:0] bit_reg;       // 0..7 data bits, 8 acknowledge slot
    logic [7:0] shift_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] base_reg;
    logic [5:0] nbytes_reg;
    logic ack_reg;
    logic sda_lo_reg;
    logic [7:0] mem [MEM_BYTES];
    logic [7:0] pbuf [PAGE_BYTES];
    logic [$clog2(EW_CNT+1)-1:0] ew_cnt_reg;
    logic [5:0] commit_reg;
    logic ew_start;
    logic [7:0] rx_byte;
    logic [PAGE_BITS-1:0] commit_lo;

    // Page increment, five low bits only
    function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
        page_inc = {a[ADDR_W-1:PAGE_BITS], a[PAGE_BITS-1:0] + 5'h01};
    endfunction

    assign rx_byte = {shift_reg[6:0], sda_s};
    assign busy = (ew_cnt_reg != '0);
    assign cur_addr = addr_reg;
    assign ew_start = stop_det && state_reg == ST_WDATA && nbytes_reg != 6'h00;

    // Bit counter and shift register
    always_ff @(posedge clk) begin
        if (srst) begin
            bit_reg <= 4'h0;
            shift_reg <= 8'h00;
        end else if (start_det) begin
            // Parked below zero: the clock fall after START carries no bit
            bit_reg <= 4'hf;
            shift_reg <= 8'h00;
        end else if (scl_rise && bit_reg < 4'h8) begin
            shift_reg <= rx_byte;
        end else if (scl_fall && state_reg != ST_IDLE) begin
            bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
        end
    end

    // Main transfer sequencing
    always_ff @(posedge clk) begin
        if (srst || stop_det) begin
            state_reg <= ST_IDLE;
            ack_reg <= 1'b0;
            nbytes_reg <= 6'h00;
        end else if (start_det) begin
            state_reg <= ST_SEL;
            ack_reg <= 1'b0;
            nbytes_reg <= 6'h00;
        end else if (scl_rise && bit_reg == 4'h7) begin
            case (state_reg)
                ST_SEL: begin
                    // Silent while mismatched or writing
                    ack_reg <= rx_byte[7:SEL_TYPE_LSB] == TYPE_CODE && !busy;
                    if (rx_byte[7:SEL_TYPE_LSB] != TYPE_CODE || busy) begin
                        state_reg <= ST_IDLE;
                    end else if (rx_byte[SEL_RW_BIT]) begin
                        state_reg <= ST_RDATA;
                    end else begin
                        state_reg <= ST_WADDR;
                    end
                end
                ST_WADDR: begin
                    ack_reg <= 1'b1;
                    state_reg <= ST_WDATA;
                end
                ST_WDATA: begin
                    ack_reg <= !wp_s;
                    if (!wp_s && nbytes_reg != 6'(PAGE_BYTES)) begin
                        nbytes_reg <= nbytes_reg + 6'h01;
                    end
                end
                ST_RDATA: ack_reg <= 1'b0;
                default: state_reg <= ST_IDLE;
            endcase
        end else if (scl_rise && bit_reg == 4'h8 && state_reg == ST_RDATA) begin
            // Master no-acknowledge ends the read
            if (sda_s) begin
                state_reg <= ST_RACK;
            end
        end else if (scl_fall && bit_reg == 4'h8) begin
            ack_reg <= 1'b0;
        end
    end

    // Address pointer and write start address
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_reg <= '0;
            base_reg <= '0;
        end else if (scl_rise && bit_reg == 4'h7 && state_reg == ST_SEL
                     && rx_byte[7:SEL_TYPE_LSB] == TYPE_CODE && !busy) begin
            addr_reg[ADDR_W-1 -: 3] <= rx_byte[SEL_BLK_LSB +: 3];
        end else if (scl_rise && bit_reg == 4'h7 && state_reg == ST_WADDR) begin
            addr_reg <= {addr_reg[ADDR_W-1 -: 3], rx_byte};
            base_reg <= {addr_reg[ADDR_W-1 -: 3], rx_byte};
        end else if (scl_rise && bit_reg == 4'h7 && state_reg == ST_WDATA && !wp_s) begin
            addr_reg <= page_inc(addr_reg);
        end else if (scl_rise && bit_reg == 4'h8 && state_reg == ST_RDATA && !ack_reg) begin
            // Own acknowledge of the selection byte leaves the pointer alone
            addr_reg <= addr_reg + 11'h001;
        end
    end

    // Latch data bytes of the page
    always_ff @(posedge clk) begin
        if (scl_rise && bit_reg == 4'h7 && state_reg == ST_WDATA && !wp_s) begin
            pbuf[addr_reg[PAGE_BITS-1:0]] <= rx_byte;
        end
    end

    // Internal erase/write timer
    always_ff @(posedge clk) begin
        if (srst) begin
            ew_cnt_reg <= '0;
            commit_reg <= 6'h00;
        end else if (ew_start) begin
            ew_cnt_reg <= ($clog2(EW_CNT+1))'(EW_CNT);
            commit_reg <= nbytes_reg;
        end else if (ew_cnt_reg != '0) begin
            ew_cnt_reg <= ew_cnt_reg - 1'b1;
            if (commit_reg != 6'h00) begin
                commit_reg <= commit_reg - 6'h01;
            end
        end
    end

    // Slot being committed, counted down from the last one
    assign commit_lo = base_reg[PAGE_BITS-1:0] + 5'(commit_reg) - 5'h01;

    // Commit page buffer one byte per cycle
    always_ff @(posedge clk) begin
        if (ew_cnt_reg != '0 && commit_reg != 6'h00) begin
            mem[{base_reg[ADDR_W-1:PAGE_BITS], commit_lo}] <= pbuf[commit_lo];
        end
    end

    // SDA drive: ack slot or read data bits
    always_ff @(posedge clk) begin
        if (srst || start_det || stop_det) begin
            sda_lo_reg <= 1'b0;
        end else if (scl_fall) begin
            if (bit_reg == 4'h7) begin
                sda_lo_reg <= ack_reg;
            end else if (state_reg == ST_RDATA && bit_reg == 4'h8) begin
                sda_lo_reg <= !mem[addr_reg][7];
            end else if (state_reg == ST_RDATA && bit_reg < 4'h7) begin
                sda_lo_reg <= !mem[addr_reg][3'(6 - bit_reg)];
            end else begin
                sda_lo_reg <= 1'b0;
            end
        end
    end

    assign bus.sda_dev_o = 1'b0;
    assign bus.sda_dev_oe = sda_lo_reg;
endmodule
`default_nettype wire

/* File: rtl/eei_host.sv */
`default_nettype none
module eei_host
    import eei_pkg::*;
#(
    parameter int HALF = SCL_DIV_DEFAULT
) (
    input wire logic clk,
    input wire logic srst,
    eei_if.host bus,
    input wire logic req,
    input wire logic rd,
    input wire logic stop_req,
    input wire logic last,
    input wire logic [7:0] wdata,
    output logic ready,
    output logic done,
    output logic [7:0] rdata,
    output logic ack_ok
);
    // =====================================================
    // Sampled bus data line
    logic [1:0] sda_sync_reg;

    // Two-flop synchroniser; the clock line is ours, so it is not read back
    always_ff @(posedge clk) begin
        sda_sync_reg <= {sda_sync_reg[0], bus.sda};
    end

    typedef enum logic [2:0] {
        H_IDLE, H_START, H_BIT, H_STOP, H_HOLD
    } eei_hstate_e;

    eei_hstate_e st_reg;
    logic [$clog2(HALF+1)-1:0] div_reg;
    logic [1:0] ph_reg;
    logic [3:0] bit_reg;
    logic [7:0] sh_reg;
    logic rd_reg, rd_mode_reg, last_reg, scl_lo_reg, sda_lo_reg;
    logic tick, start_now;

    assign tick = (div_reg == '0);
    // START from idle, or a restart that turns a write into a read
    assign start_now = (st_reg == H_IDLE) || (rd && !rd_mode_reg);
    assign ready = (st_reg == H_IDLE || st_reg == H_HOLD);

    // Quarter-period divider
    always_ff @(posedge clk) begin
        if (srst || ready) begin
            div_reg <= ($clog2(HALF+1))'(HALF / 2);
        end else begin
            div_reg <= tick ? ($clog2(HALF+1))'(HALF / 2) : div_reg - 1'b1;
        end
    end

    // Byte engine: START, 9 bits, STOP
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= H_IDLE;
            scl_lo_reg <= 1'b0;
            sda_lo_reg <= 1'b0;
            ph_reg <= 2'h0;
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            rd_reg <= 1'b0;
            rd_mode_reg <= 1'b0;
            last_reg <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
            ack_ok <= 1'b0;
        end else begin
            done <= 1'b0;
            case (st_reg)
                H_IDLE, H_HOLD: begin
                    if (req && stop_req && st_reg == H_HOLD) begin
                        st_reg <= H_STOP;
                        ph_reg <= 2'h0;
                    end else if (req && !stop_req) begin
                        // START from idle or for a restart, else straight into the data bits
                        st_reg <= start_now ? H_START : H_BIT;
                        sh_reg <= wdata;
                        rd_reg <= rd && !start_now;
                        rd_mode_reg <= rd;
                        last_reg <= last;
                        bit_reg <= 4'h0;
                        ph_reg <= 2'h0;
                    end
                end
                H_START: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    case (ph_reg)
                        2'h0: sda_lo_reg <= 1'b0;
                        2'h1: scl_lo_reg <= 1'b0;
                        2'h2: sda_lo_reg <= 1'b1;
                        default: begin
                            scl_lo_reg <= 1'b1;
                            st_reg <= H_BIT;
                            rd_reg <= 1'b0;
                        end
                    endcase
                end
                H_BIT: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    case (ph_reg)
                        2'h0: begin
                            if (bit_reg == 4'h8) begin
                                sda_lo_reg <= rd_reg && !last_reg;
                            end else begin
                                sda_lo_reg <= !rd_reg && !sh_reg[7];
                            end
                        end
                        2'h1: scl_lo_reg <= 1'b0;
                        2'h2: begin
                            if (bit_reg == 4'h8) begin
                                ack_ok <= !sda_sync_reg[1];
                            end else begin
                                sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
                            end
                        end
                        default: begin
                            scl_lo_reg <= 1'b1;
                            if (bit_reg == 4'h8) begin
                                st_reg <= H_HOLD;
                                sda_lo_reg <= 1'b0;
                                rdata <= sh_reg;
                                done <= 1'b1;
                            end
                            bit_reg <= bit_reg + 4'h1;
                        end
                    endcase
                end
                H_STOP: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    case (ph_reg)
                        2'h0: sda_lo_reg <= 1'b1;
                        2'h1: scl_lo_reg <= 1'b0;
                        2'h2: sda_lo_reg <= 1'b0;
                        default: begin
                            st_reg <= H_IDLE;
                            done <= 1'b1;
                        end
                    endcase
                end
                default: st_reg <= H_IDLE;
            endcase
        end
    end

    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = scl_lo_reg;
    assign bus.sda_host_o = 1'b0;
    assign bus.sda_host_oe = sda_lo_reg;
endmodule
`default_nettype wire

/* File: shared/eei_if.sv */
`default_nettype none
interface eei_if;
    logic scl_o;
    logic scl_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;
    // Open-drain wired-AND with pull-ups
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);
    modport host (output scl_o, output scl_oe, output sda_host_o, output sda_host_oe,
                  input scl, input sda);
    modport dev (output sda_dev_o, output sda_dev_oe, input scl, input sda);
endinterface
`default_nettype wire

/* File: shared/eei_pkg.sv */
`default_nettype none
package eei_pkg;
    // =====================================================
    // Memory organisation
    localparam int MEM_BYTES = 2048;
    localparam int ADDR_W = 11;
    localparam int PAGE_BITS = 5;
    localparam int PAGE_BYTES = 32;
    // =====================================================
    // Selection byte layout
    localparam logic [3:0] TYPE_CODE = 4'h6; // Device type code, value is arbitrary
    localparam int SEL_TYPE_LSB = 4;
    localparam int SEL_BLK_LSB = 1;
    localparam int SEL_RW_BIT = 0;
    // =====================================================
    // Timing
    localparam int CLK_HZ = 125_000_000;
    localparam int EW_TIME_US = 10_000;
    localparam int EW_CYCLES = EW_TIME_US * (CLK_HZ / 1_000_000);
    localparam int SCL_DIV_DEFAULT = 156; // half period, 400 kHz
endpackage
`default_nettype wire

/* File: testbench/eei_properties.sv */
`default_nettype none
module eei_properties (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic scl,
    input wire logic sda
);
    // ==========
    // Bus events
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence

    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence

    sequence s_clock_drop;
        ##[1:200] $fell(scl);
    endsequence

    // ==========
    // Wire checks
    a_idle_after_reset: assert property ($fell(srst) |-> scl && sda)
        else $error("bus not idle after reset");
    a_start_then_clock: assert property (s_start |-> !sda throughout s_clock_drop)
        else $error("start not followed by clock low");
    a_stop_leaves_idle: assert property (s_stop |=> (scl && sda && !sda_dev_oe) [*4])
        else $error("bus not idle after stop");
    a_dev_data_stable: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
        else $error("device moved data while clock high");
    a_host_change_control: assert property (
        scl && $past(scl) && $changed(sda_host_oe) |-> $fell(sda) || $rose(sda))
        else $error("host data change while clock high is not start or stop");
    a_ack_held_low: assert property (
        $rose(scl) && sda_dev_oe |-> sda_dev_oe throughout s_clock_drop)
        else $error("device low not held through clock high");
    a_dev_pulls_low: assert property (sda_dev_oe |-> !sda_dev_o && !sda)
        else $error("device drive is not a low level");
    a_host_pulls_low: assert property (sda_host_oe |-> !sda_host_o && !sda)
        else $error("host data drive is not a low level");
    a_clock_pulls_low: assert property (scl_oe |-> !scl_o && !scl)
        else $error("host clock drive is not a low level");
    a_scl_high_pulse: assert property ($rose(scl) |-> scl [*3])
        else $error("clock high pulse too short");
    a_scl_low_pulse: assert property ($fell(scl) |-> !scl [*3])
        else $error("clock low pulse too short");
endmodule
`default_nettype wire

/* File: testbench/serial_eeprom_i2c_slave_tb.sv */
`default_nettype none
module serial_eeprom_i2c_slave_tb import eei_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF_SIM = 8;
    localparam int EW_SIM = 200;
    localparam int LIMIT = 5000;
    logic clk, srst, wp, req, rd, stop_req, last, ready, done, ack_ok, busy;
    logic [7:0] wdata, rdata, sh, wire_byte, sel;
    logic [ADDR_W-1:0] cur_addr;
    logic scl_d = 1'b1;
    logic sda_d = 1'b1;
    logic wire_ack = 1'b1;
    int bitn = 0;
    int num_errors = 0;
    int total_checks = 0;
    int mem [MEM_BYTES];
    int blk_addr [8];
    int maddr;

    eei_if bus_if ();
    eei_host #(.HALF(HALF_SIM)) eei_host_inst (.clk(clk), .srst(srst), .bus(bus_if.host),
        .req(req), .rd(rd), .stop_req(stop_req), .last(last), .wdata(wdata), .ready(ready),
        .done(done), .rdata(rdata), .ack_ok(ack_ok));
    eei_dev #(.EW_CNT(EW_SIM)) eei_dev_inst (.clk(clk), .srst(srst), .bus(bus_if.dev), .wp(wp),
        .busy(busy), .cur_addr(cur_addr));
    eei_properties eei_properties_inst (.clk(clk), .srst(srst), .scl_o(bus_if.scl_o),
        .scl_oe(bus_if.scl_oe), .sda_host_o(bus_if.sda_host_o), .sda_host_oe(bus_if.sda_host_oe),
        .sda_dev_o(bus_if.sda_dev_o), .sda_dev_oe(bus_if.sda_dev_oe), .scl(bus_if.scl),
        .sda(bus_if.sda));

    // Clock source
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========
    // Wire monitor: bytes and acknowledge seen at clock rises
    always @(posedge clk) begin
        scl_d <= bus_if.scl;
        sda_d <= bus_if.sda;
        if (bus_if.scl && scl_d && sda_d && !bus_if.sda) begin
            bitn <= 0;
        end else if (bus_if.scl && !scl_d) begin
            if (bitn == 8) begin
                wire_ack <= bus_if.sda;
                bitn <= 0;
            end else begin
                sh <= {sh[6:0], bus_if.sda};
                if (bitn == 7) wire_byte <= {sh[6:0], bus_if.sda};
                bitn <= bitn + 1;
            end
        end
    end

    // ==========
    // Compare and closing report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Bounded wait on a level
    task automatic wait_for(ref logic sig, input logic lvl);
        int n;
        n = 0;
        while (sig !== lvl) begin
            @(negedge clk);
            n++;
            if (n > LIMIT) begin
                num_errors++;
                $display("wrong value at %0t: wait ran out", $time);
                complete_run();
            end
        end
    endtask

    // ==========
    // Host requests
    task automatic xfer(input logic [7:0] b, input logic r, input logic s, input logic l);
        wait_for(ready, 1'b1);
        req = 1'b1;
        rd = r;
        stop_req = s;
        last = l;
        wdata = b;
        @(negedge clk);
        req = 1'b0;
        wait_for(done, 1'b1);
    endtask

    task automatic put(input logic [7:0] b, input logic r, input logic exp_ack);
        xfer(b, r, 1'b0, 1'b0);
        check(16'(wire_byte), 16'(b), "wire byte");
        check(16'(ack_ok), 16'(exp_ack), "host ack");
        check(16'(wire_ack), 16'(!exp_ack), "wire ack");
    endtask

    task automatic set_addr(input int a);
        put({TYPE_CODE, 3'(a >> 8), 1'b0}, 1'b0, 1'b1);
        put(8'(a), 1'b0, 1'b1);
        maddr = a;
    endtask

    task automatic write_page(input int a, input int n);
        logic [7:0] d;
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            put(d, 1'b0, !wp);
            if (!wp) mem[maddr] = int'(d);
            maddr = (maddr & ~(PAGE_BYTES - 1)) | ((maddr + 1) % PAGE_BYTES);
        end
        xfer(8'h00, 1'b0, 1'b1, 1'b0);
        if (!wp) check(16'(cur_addr), 16'(maddr), "pointer");
        if (!wp) wait_for(busy, 1'b1);
    endtask

    task automatic read_seq(input int a, input int n);
        set_addr(a);
        put({TYPE_CODE, 3'(a >> 8), 1'b1}, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            xfer(8'h00, 1'b1, 1'b0, i == n - 1);
            check(16'(rdata), 16'(mem[maddr]), "read data");
            check(16'(wire_byte), 16'(mem[maddr]), "wire data");
            check(16'(wire_ack), 16'(i == n - 1), "master ack");
            maddr = (maddr + 1) % MEM_BYTES;
        end
        repeat (6) @(negedge clk);
        check(16'(bus_if.sda_dev_oe), 16'h0, "released");
        xfer(8'h00, 1'b0, 1'b1, 1'b0);
    endtask

    // ==========
    // Main sequence
    initial begin
        srst = 1'b1;
        wp = 1'b0;
        req = 1'b0;
        rd = 1'b0;
        stop_req = 1'b0;
        last = 1'b0;
        wdata = 8'h00;
        void'($urandom(42));
        repeat (3) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        write_page(32'h1fd, 6);
        put({TYPE_CODE, 3'h1, 1'b0}, 1'b0, 1'b0);
        xfer(8'h00, 1'b0, 1'b1, 1'b0);
        wait_for(busy, 1'b0);
        read_seq(32'h1e0, 3);
        read_seq(32'h1fd, 3);
        $display("test page wrap and timer done");
        for (int k = 0; k < 8; k++) begin
            blk_addr[k] = k * 256 + int'($urandom % 256);
            write_page(blk_addr[k], 1);
            wait_for(busy, 1'b0);
        end
        for (int k = 0; k < 8; k++) begin
            read_seq(blk_addr[k], 1);
        end
        $display("test block select done");
        write_page(32'h7fe, 2);
        wait_for(busy, 1'b0);
        write_page(32'h000, 2);
        wait_for(busy, 1'b0);
        read_seq(32'h7fe, 4);
        $display("test read wrap done");
        wp = 1'b1;
        write_page(blk_addr[3], 2);
        wp = 1'b0;
        read_seq(blk_addr[3], 1);
        $display("test write protect done");
        for (int k = 0; k < 4; k++) begin
            sel = 8'($urandom);
            if (sel[7:4] == TYPE_CODE) sel[7:4] = ~TYPE_CODE;
            put(sel & 8'hfe, 1'b0, 1'b0);
            put(8'($urandom), 1'b0, 1'b0);
            xfer(8'h00, 1'b0, 1'b1, 1'b0);
        end
        $display("test type mismatch done");
        complete_run();
    end
endmodule
`default_nettype wire
